// [core/apsi_ctrl.sv]
// Host controller driving the async page pseudo-static memory pins
`timescale 1ns/10ps
// Summary of operation
// - Page mode chip select under 8 us
// - Write strobe never low over 8 us
// - Byte lanes, address, select 70 ns per write
// - Write data 23 ns before write end
// - Chip select high 5 ns between writes
// - Write strobe high 10 ns between pulses
// - Deselect 5 ns before sleep pin low
// - Deep power-down sleep held 10 us
// - Wait 150 us after power-up
// - Wait 150 us after deep power-down exit
module apsi_ctrl
  import apsi_pkg::*;
#(
  parameter int INIT_CYCLES = APSI_INIT_CYC,
  parameter int DPD_CYCLES = APSI_DPD_CYC,
  parameter int CS_MAX_CYCLES = APSI_CSMAX_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [APSI_ADDR_W-1:0] cmd_addr,
  input wire logic [APSI_DATA_W-1:0] cmd_wdata,
  input wire logic [1:0] cmd_be,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [APSI_DATA_W-1:0] rsp_rdata,
  output logic init_done,
  output logic [APSI_ADDR_W-1:0] mem_addr,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic write_n,
  output logic low_byte_sel_n,
  output logic high_byte_sel_n,
  output logic sleep_request_n,
  output logic [APSI_DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [APSI_DATA_W-1:0] mem_dq_in
);
  typedef struct packed {
    apsi_state_type st;
    logic [APSI_DATA_W-1:0] dq_s1;
    logic [APSI_DATA_W-1:0] dq_s2;
    logic [20:0] cfg;
    logic cfg_cycle;
    logic deep_powerdown;
    logic ready;
    logic rvalid;
    logic [APSI_DATA_W-1:0] rdata;
    logic initd;
    logic [APSI_ADDR_W-1:0] addr;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic lb_n;
    logic hb_n;
    logic zz_n;
    logic [APSI_DATA_W-1:0] dout;
    logic doe;
    logic [APSI_CNT_W-1:0] cyc;
    logic [APSI_CNT_W-1:0] lz;
  } apsi_ctrl_type;
  apsi_ctrl_type s_reg, s_next;

  // Read data reaches the sample point only after the two pin flops
  localparam int SYNC_CYC = 2;
  // Cycles of select spent outside the timed part of a page burst
  localparam int PG_SLACK = 2 * SYNC_CYC + 2;

  logic tmr_load;
  logic [APSI_CNT_W-1:0] tmr_count;
  logic tmr_busy;
  logic tmr_done;

  // Long waits live in the shared timer, which is as wide as the main counter (APSI_CNT_W bits)
  apsi_timer #(.WIDTH(APSI_CNT_W)) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(tmr_load),
    .count(tmr_count),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  function automatic logic [APSI_CNT_W-1:0] cyc_of(input int n);
    return APSI_CNT_W'(n);
  endfunction

  always_comb begin
    s_next = s_reg;
    tmr_load = 1'b0;
    tmr_count = '0;
    s_next.dq_s1 = mem_dq_in;
    s_next.dq_s2 = s_reg.dq_s1;
    s_next.rvalid = 1'b0;
    s_next.cyc = s_reg.cyc + cyc_of(1);
    if (s_reg.lz != '0) begin
      s_next.lz = s_reg.lz - cyc_of(1);
    end
    case (s_reg.st)
      APSI_ST_INIT: begin
        if (!tmr_busy && !tmr_done && s_reg.cyc == '0) begin
          tmr_load = 1'b1;
          tmr_count = cyc_of(INIT_CYCLES);
        end else if (tmr_done) begin
          s_next.st = APSI_ST_IDLE;
          s_next.initd = 1'b1;
          s_next.ready = 1'b1;
        end
      end
      APSI_ST_IDLE: begin
        s_next.cyc = '0;
        if (cmd_valid && s_reg.ready && s_reg.lz == '0) begin
          s_next.ready = 1'b0;
          s_next.addr = cmd_addr;
          s_next.lb_n = ~cmd_be[0];
          s_next.hb_n = ~cmd_be[1];
          case (cmd_op)
            APSI_CMD_READ, APSI_CMD_PAGE: begin
              s_next.cs_n = 1'b0;
              s_next.oe_n = 1'b0;
              s_next.st = APSI_ST_RD;
            end
            APSI_CMD_WRITE: begin
              s_next.cs_n = 1'b0;
              s_next.we_n = 1'b0;
              s_next.dout = cmd_wdata;
              s_next.doe = 1'b1;
              s_next.st = APSI_ST_WR;
            end
            APSI_CMD_CONFIG, APSI_CMD_SLEEP: begin
              s_next.cfg_cycle = (cmd_op == APSI_CMD_CONFIG);
              s_next.dout = cmd_wdata;
              s_next.st = APSI_ST_DESEL;
            end
            default: begin
              s_next.ready = 1'b1;
            end
          endcase
        end
      end
      APSI_ST_RD: begin
        if (s_reg.cyc == cyc_of(APSI_RD_CYC + SYNC_CYC)) begin
          s_next.rdata = s_reg.dq_s2;
          s_next.rvalid = 1'b1;
          s_next.cyc = '0;
          // Page reads keep select low only when the memory allows it
          if (cmd_valid && cmd_op == APSI_CMD_PAGE && s_reg.cfg[APSI_CFG_PAGE_BIT]
              && cmd_addr[APSI_ADDR_W-1:4] == s_reg.addr[APSI_ADDR_W-1:4]) begin
            s_next.addr = cmd_addr;
            s_next.st = APSI_ST_PG;
          end else begin
            s_next.cs_n = 1'b1;
            s_next.oe_n = 1'b1;
            s_next.lb_n = 1'b1;
            s_next.hb_n = 1'b1;
            s_next.st = APSI_ST_CSH;
          end
        end
      end
      APSI_ST_PG: begin
        if (s_reg.cyc == cyc_of(APSI_PG_CYC + SYNC_CYC)) begin
          s_next.rdata = s_reg.dq_s2;
          s_next.rvalid = 1'b1;
          s_next.cyc = '0;
          // Timer busy means one more page step still fits the select limit
          if (cmd_valid && cmd_op == APSI_CMD_PAGE && tmr_busy
              && cmd_addr[APSI_ADDR_W-1:4] == s_reg.addr[APSI_ADDR_W-1:4]) begin
            s_next.addr = cmd_addr;
          end else begin
            s_next.cs_n = 1'b1;
            s_next.oe_n = 1'b1;
            s_next.lb_n = 1'b1;
            s_next.hb_n = 1'b1;
            s_next.st = APSI_ST_CSH;
          end
        end
      end
      APSI_ST_WR: begin
        if (s_reg.cyc == cyc_of(APSI_WR_CYC)) begin
          s_next.we_n = 1'b1;
          s_next.cs_n = 1'b1;
          s_next.lb_n = 1'b1;
          s_next.hb_n = 1'b1;
          s_next.doe = 1'b0;
          s_next.lz = cyc_of(APSI_LZ_CYC);
          s_next.cyc = '0;
          s_next.rvalid = s_reg.cfg_cycle;
          s_next.st = s_reg.cfg_cycle ? APSI_ST_ZZ : APSI_ST_CSH;
        end
      end
      APSI_ST_CSH: begin
        // Select and strobe both rest high before the next cycle
        if (s_reg.cyc >= cyc_of(APSI_WEH_CYC) && s_reg.cyc >= cyc_of(APSI_CSH_CYC)) begin
          s_next.st = APSI_ST_IDLE;
          s_next.ready = 1'b1;
          if (!s_reg.initd) begin
            s_next.st = APSI_ST_INIT;
          end
        end
      end
      APSI_ST_DESEL: begin
        if (s_reg.cyc == cyc_of(APSI_DZ_CYC)) begin
          s_next.zz_n = 1'b0;
          s_next.cyc = '0;
          s_next.deep_powerdown = !s_reg.cfg[APSI_CFG_SLEEP_BIT];
          if (s_reg.cfg_cycle) begin
            s_next.st = APSI_ST_CFGWR;
          end else begin
            s_next.st = APSI_ST_DPD;
            tmr_load = 1'b1;
            tmr_count = cyc_of(DPD_CYCLES);
          end
        end
      end
      APSI_ST_CFGWR: begin
        if (s_reg.cyc == cyc_of(APSI_ZW_CYC)) begin
          s_next.we_n = 1'b0;
          s_next.cs_n = 1'b0;
          s_next.doe = 1'b1;
          s_next.cfg = {5'h00, s_reg.dout};
          s_next.cyc = '0;
          s_next.st = APSI_ST_WR;
        end
      end
      APSI_ST_ZZ: begin
        s_next.zz_n = 1'b1;
        s_next.cfg_cycle = 1'b0;
        s_next.st = APSI_ST_CSH;
      end
      APSI_ST_DPD: begin
        if (tmr_done) begin
          s_next.zz_n = 1'b1;
          s_next.rvalid = 1'b1;
          if (s_reg.deep_powerdown) begin
            s_next.initd = 1'b0;
            s_next.cfg = APSI_CFG_RESET;
            tmr_load = 1'b1;
            tmr_count = cyc_of(INIT_CYCLES);
            s_next.st = APSI_ST_REC;
          end else begin
            s_next.st = APSI_ST_CSH;
          end
        end
      end
      APSI_ST_REC: begin
        if (tmr_done) begin
          s_next.initd = 1'b1;
          s_next.ready = 1'b1;
          s_next.st = APSI_ST_IDLE;
        end
      end
      default: begin
        s_next.st = APSI_ST_INIT;
      end
    endcase
    // Page bursts are cut by the timer before select exceeds its limit
    if (s_reg.st == APSI_ST_RD && s_next.st == APSI_ST_PG) begin
      tmr_load = 1'b1;
      tmr_count = cyc_of(CS_MAX_CYCLES - APSI_RD_CYC - APSI_PG_CYC - PG_SLACK);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{st: APSI_ST_INIT, cfg: APSI_CFG_RESET, cs_n: 1'b1, oe_n: 1'b1,
                 we_n: 1'b1, lb_n: 1'b1, hb_n: 1'b1, zz_n: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmd_ready = s_reg.ready;
  assign rsp_valid = s_reg.rvalid;
  assign rsp_rdata = s_reg.rdata;
  assign init_done = s_reg.initd;
  assign mem_addr = s_reg.addr;
  assign chip_sel_n = s_reg.cs_n;
  assign out_gate_n = s_reg.oe_n;
  assign write_n = s_reg.we_n;
  assign low_byte_sel_n = s_reg.lb_n;
  assign high_byte_sel_n = s_reg.hb_n;
  assign sleep_request_n = s_reg.zz_n;
  assign mem_dq_out = s_reg.dout;
  assign mem_dq_oe = s_reg.doe;
endmodule // apsi_ctrl

// [core/apsi_pkg.sv]
// Constants and types for the async page pseudo-static memory controller
package apsi_pkg;
  localparam int APSI_CLK_PS = 4000;
  // Least times round up, longest times round down, never below one cycle
  function automatic int apsi_min_cyc(input int t_ps);
    int c;
    c = (t_ps + APSI_CLK_PS - 1) / APSI_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  function automatic int apsi_max_cyc(input int t_ps);
    int c;
    c = t_ps / APSI_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int APSI_T_READ_NS = 70;
  localparam int APSI_T_PAGE_NS = 20;
  localparam int APSI_T_HZ_NS = 8;
  localparam int APSI_T_WRITE_NS = 70;
  localparam int APSI_T_DATA_SETUP_NS = 23;
  localparam int APSI_T_CS_HIGH_NS = 5;
  localparam int APSI_T_WE_HIGH_NS = 10;
  localparam int APSI_T_DESEL_SLEEP_NS = 5;
  localparam int APSI_T_SLEEP_WE_MIN_NS = 10;
  localparam int APSI_T_SLEEP_WE_MAX_NS = 500;
  localparam int APSI_T_END_LZ_NS = 5;
  localparam int APSI_T_CS_MAX_US = 8;
  localparam int APSI_T_DPD_US = 10;
  localparam int APSI_T_INIT_US = 150;
  localparam int APSI_RD_CYC = apsi_min_cyc(APSI_T_READ_NS * 1000);
  localparam int APSI_PG_CYC = apsi_min_cyc(APSI_T_PAGE_NS * 1000);
  localparam int APSI_HZ_CYC = apsi_min_cyc(APSI_T_HZ_NS * 1000);
  localparam int APSI_WR_CYC = apsi_min_cyc(APSI_T_WRITE_NS * 1000);
  localparam int APSI_DS_CYC = apsi_min_cyc(APSI_T_DATA_SETUP_NS * 1000);
  localparam int APSI_CSH_CYC = apsi_min_cyc(APSI_T_CS_HIGH_NS * 1000);
  localparam int APSI_WEH_CYC = apsi_min_cyc(APSI_T_WE_HIGH_NS * 1000);
  localparam int APSI_DZ_CYC = apsi_min_cyc(APSI_T_DESEL_SLEEP_NS * 1000);
  localparam int APSI_ZW_CYC = apsi_min_cyc(APSI_T_SLEEP_WE_MIN_NS * 1000);
  localparam int APSI_ZW_MAX_CYC = apsi_max_cyc(APSI_T_SLEEP_WE_MAX_NS * 1000);
  localparam int APSI_LZ_CYC = apsi_min_cyc(APSI_T_END_LZ_NS * 1000);
  localparam int APSI_CSMAX_CYC = apsi_max_cyc(APSI_T_CS_MAX_US * 1000000);
  localparam int APSI_DPD_CYC = apsi_min_cyc(APSI_T_DPD_US * 1000000);
  localparam int APSI_INIT_CYC = apsi_min_cyc(APSI_T_INIT_US * 1000000);
  localparam int APSI_ADDR_W = 21;
  localparam int APSI_DATA_W = 16;
  localparam int APSI_CNT_W = 16;
  localparam int APSI_CFG_SLEEP_BIT = 4;
  localparam int APSI_CFG_PAGE_BIT = 7;
  localparam logic [20:0] APSI_CFG_RESET = 21'h000070;
  // Commands on the user port
  localparam logic [2:0] APSI_CMD_READ = 3'h0;
  localparam logic [2:0] APSI_CMD_WRITE = 3'h1;
  localparam logic [2:0] APSI_CMD_CONFIG = 3'h2;
  localparam logic [2:0] APSI_CMD_SLEEP = 3'h3;
  localparam logic [2:0] APSI_CMD_PAGE = 3'h4;
  typedef enum logic [10:0] {
    APSI_ST_INIT = 11'h001,
    APSI_ST_IDLE = 11'h002,
    APSI_ST_RD = 11'h004,
    APSI_ST_PG = 11'h008,
    APSI_ST_WR = 11'h010,
    APSI_ST_CSH = 11'h020,
    APSI_ST_DESEL = 11'h040,
    APSI_ST_ZZ = 11'h080,
    APSI_ST_CFGWR = 11'h100,
    APSI_ST_DPD = 11'h200,
    APSI_ST_REC = 11'h400
  } apsi_state_type;
endpackage

// [core/apsi_timer.sv]
// Down-counting delay timer, pulses done when it reaches zero
`timescale 1ns/10ps
module apsi_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic busy;
    logic done;
  } apsi_tmr_type;
  apsi_tmr_type s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (load) begin
      s_next.cnt = count;
      s_next.busy = 1'b1;
    end else if (s_reg.busy) begin
      if (s_reg.cnt <= WIDTH'(1)) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.cnt = '0;
      end else begin
        s_next.cnt = s_reg.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy = s_reg.busy;
  assign done = s_reg.done;
endmodule // apsi_timer

// [dv/apsi_mem_model.sv]
// Behavioural model of the pseudo-static memory behind the controller
`timescale 1ns/10ps
module apsi_mem_model (
  input wire logic clk,
  input wire logic [20:0] mem_addr,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic write_n,
  input wire logic low_byte_sel_n,
  input wire logic high_byte_sel_n,
  input wire logic sleep_request_n,
  input wire logic [15:0] mem_dq_out,
  output logic [15:0] mem_dq_in
);
  logic [15:0] mem [0:255];
  logic [20:0] cfg = 21'h000070; // Page reads off at power-up
  logic [15:0] rd_q = 16'h0000;
  logic vld = 1'b0;
  logic [20:0] last_a = 21'h000000;
  realtime t_ev = 0.0;
  realtime need = 70.0;
  always @(chip_sel_n, out_gate_n, write_n, mem_addr) begin
    // Fast access only inside an open page
    need = (cfg[7] && vld && mem_addr[20:4] == last_a[20:4]) ? 20.0 : 70.0;
    last_a = mem_addr;
    t_ev = $realtime;
  end
  always #1 begin
    if (chip_sel_n || out_gate_n || !write_n)
      vld = 1'b0; // Floats at once, inside 8 ns
    else if ($realtime - t_ev >= need) begin
      vld = 1'b1; // No drive soon after a write end
      rd_q = mem[mem_addr[7:0]];
    end else if ($realtime - t_ev >= 5.0)
      vld = 1'b0; // Old word held 5 ns after a move
  end
  // Released lanes show the inverse, not a convenient stale value
  assign mem_dq_in[7:0] = (vld && !low_byte_sel_n) ? rd_q[7:0] : ~rd_q[7:0];
  assign mem_dq_in[15:8] = (vld && !high_byte_sel_n) ? rd_q[15:8] : ~rd_q[15:8];
  always @(posedge clk) begin
    if (!chip_sel_n && !write_n && sleep_request_n && !low_byte_sel_n)
      mem[mem_addr[7:0]][7:0] <= mem_dq_out[7:0];
    if (!chip_sel_n && !write_n && sleep_request_n && !high_byte_sel_n)
      mem[mem_addr[7:0]][15:8] <= mem_dq_out[15:8];
    if (!chip_sel_n && !write_n && !sleep_request_n)
      cfg <= mem_addr; // Bit 4 picks the sleep mode
  end
endmodule // apsi_mem_model

// [dv/apsi_ctrl_checker.sv]
// Pin timing checker for the memory controller
`timescale 1ns/10ps
module apsi_ctrl_checker
  import apsi_pkg::*;
#(
  parameter int INIT_CYCLES = APSI_INIT_CYC,
  parameter int DPD_CYCLES = APSI_DPD_CYC,
  parameter int CS_MAX_CYCLES = APSI_CSMAX_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_ready,
  input wire logic init_done,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic write_n,
  input wire logic sleep_request_n,
  input wire logic [APSI_DATA_W-1:0] mem_dq_out,
  input wire logic mem_dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Low-time counters; 16 bits cover the full 150 us recovery
  logic [15:0] wl_reg, cl_reg, zl_reg, nd_reg;
  logic zw_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wl_reg <= 16'h0000;
      cl_reg <= 16'h0000;
      zl_reg <= 16'h0000;
      nd_reg <= 16'h0000;
      zw_reg <= 1'b0;
    end else begin
      wl_reg <= write_n ? 16'h0000 : wl_reg + 16'h0001;
      cl_reg <= chip_sel_n ? 16'h0000 : cl_reg + 16'h0001;
      zl_reg <= sleep_request_n ? 16'h0000 : zl_reg + 16'h0001;
      nd_reg <= init_done ? 16'h0000 : nd_reg + 16'h0001;
      zw_reg <= !sleep_request_n && (zw_reg || !write_n);
    end
  end
  a_cs_max_len: assert property (cl_reg <= CS_MAX_CYCLES)
    else $error("chip select low too long");
  a_write_len: assert property ($rose(write_n) |-> wl_reg >= APSI_WR_CYC)
    else $error("write pulse too short");
  a_data_setup: assert property ($rose(write_n) && sleep_request_n |->
    $past(mem_dq_oe, 6) && $past(mem_dq_out, 6) == $past(mem_dq_out, 1))
    else $error("write data not set up");
  a_cs_gap: assert property ($rose(chip_sel_n) |-> chip_sel_n[*2])
    else $error("chip select gap too short");
  a_we_gap: assert property ($rose(write_n) |-> write_n[*3])
    else $error("write strobe gap too short");
  a_desel_sleep: assert property ($fell(sleep_request_n) |->
    chip_sel_n && $past(chip_sel_n, 1) && $past(chip_sel_n, 2))
    else $error("sleep without deselect");
  a_cfg_strobe: assert property ($fell(write_n) && !sleep_request_n |->
    zl_reg >= APSI_ZW_CYC && zl_reg <= APSI_ZW_MAX_CYC)
    else $error("config strobe out of window");
  a_dpd_hold: assert property ($rose(sleep_request_n) && !zw_reg |-> zl_reg >= DPD_CYCLES)
    else $error("sleep pulse too short");
  a_init_wait: assert property ($rose(init_done) |-> nd_reg >= INIT_CYCLES)
    else $error("init done too early");
  a_no_access: assert property (!init_done |-> chip_sel_n && !cmd_ready)
    else $error("access during init");
  a_gate_read: assert property (!out_gate_n |-> !chip_sel_n && write_n)
    else $error("output gate outside read");
endmodule // apsi_ctrl_checker
bind apsi_ctrl apsi_ctrl_checker #(.INIT_CYCLES(INIT_CYCLES), .DPD_CYCLES(DPD_CYCLES),
  .CS_MAX_CYCLES(CS_MAX_CYCLES)) chk_u (.clk, .reset_n, .cmd_ready, .init_done,
  .chip_sel_n, .out_gate_n, .write_n, .sleep_request_n, .mem_dq_out, .mem_dq_oe);

// [dv/apsi_ctrl_test.sv]
// Testbench for the memory controller against the memory model
`timescale 1ns/10ps
module apsi_ctrl_test;
  import apsi_pkg::*;
  logic clk, reset_n, cmd_valid, cmd_ready, rsp_valid, init_done, lo_seen;
  logic [2:0] cmd_op;
  logic [1:0] cmd_be;
  logic [APSI_ADDR_W-1:0] cmd_addr, mem_addr;
  logic [APSI_DATA_W-1:0] cmd_wdata, rsp_rdata, mem_dq_out, mem_dq_in;
  logic chip_sel_n, out_gate_n, write_n, low_byte_sel_n, high_byte_sel_n;
  logic sleep_request_n, mem_dq_oe;
  int n_errors = 0;
  int compares = 0;
  // Short counts keep the run small
  apsi_ctrl #(.INIT_CYCLES(50), .DPD_CYCLES(20), .CS_MAX_CYCLES(40)) dut_u (.clk, .reset_n,
    .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_be, .cmd_ready, .rsp_valid, .rsp_rdata,
    .init_done, .mem_addr, .chip_sel_n, .out_gate_n, .write_n, .low_byte_sel_n,
    .high_byte_sel_n, .sleep_request_n, .mem_dq_out, .mem_dq_oe, .mem_dq_in);
  apsi_mem_model mem_u (.clk, .mem_addr, .chip_sel_n, .out_gate_n, .write_n, .low_byte_sel_n,
    .high_byte_sel_n, .sleep_request_n, .mem_dq_out, .mem_dq_in);
  always @(posedge clk) if (reset_n && init_done === 1'b0) lo_seen <= 1'b1;
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One request; waits on ready, then on the answer pulse unless a write
  task automatic req(input logic [2:0] op, input logic [20:0] a, input logic [15:0] d,
      input logic [1:0] be, output logic [15:0] rd);
    int n;
    n = 0;
    rd = 16'h0000;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_be = be;
    while (cmd_ready !== 1'b1 && n < 50000) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    // A write waits for ready again so valid never drops and rises in one step
    while ((op == APSI_CMD_WRITE ? cmd_ready !== 1'b1 : rsp_valid !== 1'b1) && n < 50000) begin
      @(posedge clk);
      #1;
      n++;
    end
    rd = rsp_rdata;
    check(16'(n >= 50000), 16'h0000, "handshake timeout");
  endtask
  task automatic t_write_read();
    logic [15:0] rd;
    req(APSI_CMD_WRITE, 21'h000012, 16'hABCD, 2'h3, rd);
    req(APSI_CMD_WRITE, 21'h000013, 16'h2468, 2'h3, rd);
    req(APSI_CMD_READ, 21'h000012, 16'h0000, 2'h3, rd);
    check(rd, 16'hABCD, "word read");
    req(APSI_CMD_WRITE, 21'h000012, 16'h1234, 2'h1, rd);
    req(APSI_CMD_WRITE, 21'h000012, 16'h5678, 2'h2, rd);
    req(APSI_CMD_READ, 21'h000012, 16'h0000, 2'h3, rd);
    check(rd, 16'h5634, "lane merge");
  endtask
  // Two words of one row under one select; cont says whether the second follows
  task automatic page_pair(input logic [20:0] a0, input logic [20:0] a1,
      input logic [15:0] e0, input logic [15:0] e1, input logic cont);
    int n;
    int gap;
    n = 0;
    gap = 0;
    cmd_valid = 1'b1;
    cmd_op = APSI_CMD_PAGE;
    cmd_addr = a0;
    cmd_wdata = 16'h0000;
    cmd_be = 2'h3;
    while (cmd_ready !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    cmd_addr = a1;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(rsp_rdata, e0, "page first word");
    cmd_valid = 1'b0;
    @(posedge clk);
    #1;
    while (rsp_valid !== 1'b1 && gap < 2 * APSI_RD_CYC) begin
      @(posedge clk);
      #1;
      gap++;
    end
    check(16'(rsp_valid === 1'b1), 16'(cont), "page follow-on");
    if (cont) check(rsp_rdata, e1, "page next word");
    check(16'(cont && gap >= APSI_RD_CYC), 16'h0000, "page access slow");
    check(16'(n >= 1000), 16'h0000, "handshake timeout");
  endtask
  task automatic t_page();
    logic [15:0] rd;
    page_pair(21'h000013, 21'h000012, 16'h2468, 16'h5634, 1'b0);
    req(APSI_CMD_CONFIG, 21'h0000F0, 16'h00F0, 2'h3, rd);
    page_pair(21'h000012, 21'h000013, 16'h5634, 16'h2468, 1'b1);
    req(APSI_CMD_PAGE, 21'h000013, 16'h0000, 2'h3, rd);
    check(rd, 16'h2468, "page single word");
  endtask
  task automatic t_sleep();
    logic [15:0] rd;
    lo_seen = 1'b0;
    req(APSI_CMD_SLEEP, 21'h000000, 16'h0000, 2'h3, rd);
    check(16'(lo_seen), 16'h0000, "partial refresh keeps init");
    req(APSI_CMD_CONFIG, 21'h0000E0, 16'h00E0, 2'h3, rd);
    req(APSI_CMD_SLEEP, 21'h000000, 16'h0000, 2'h3, rd);
    req(APSI_CMD_WRITE, 21'h000020, 16'h0F0F, 2'h3, rd);
    check(16'(lo_seen), 16'h0001, "deep power-down recovery");
    req(APSI_CMD_READ, 21'h000020, 16'h0000, 2'h3, rd);
    check(rd, 16'h0F0F, "access after recovery");
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    // Whole run needs about five hundred cycles; twenty times that is a hang
    #40000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    int n;
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_addr = 21'h000000;
    cmd_wdata = 16'h0000;
    cmd_be = 2'h0;
    lo_seen = 1'b0;
    n = 0;
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    while (init_done !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(n >= 50 && n < 1000), 16'h0001, "init wait");
    t_write_read();
    t_page();
    t_sleep();
    summarize();
  end
endmodule // apsi_ctrl_test
